// ==== verilog/cpr_pkg.sv ====
// Purpose: Shared constants for the configuration memory reset block
// Assumes: 100 MHz reference clock
// Notes: Times in their own unit, cycle counts derived from them
package cpr_pkg;
  // Reference clock period
  localparam int unsigned CLK_PERIOD_NS = 10;
  // Release delay minimum after supply thresholds are met (plain default)
  localparam int unsigned RELEASE_DELAY_US = 1;
  // Least time rounds up to whole cycles
  localparam int unsigned RELEASE_DELAY_CYC =
    (RELEASE_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Clock output divide ratio (half period in reference cycles)
  localparam int unsigned CONFIG_CLOCK_OUT_HALF_CYC = 2;
  // Default address counter width
  localparam int unsigned ADDR_W = 16;
  // Data width of the parallel port
  localparam int unsigned DATA_W = 8;
  // Address reset value
  localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
  // Power sequencer states
  typedef enum logic [1:0] {
    CPR_RAMP,
    CPR_DELAY,
    CPR_READY
  } cpr_por_state_type;
endpackage

// ==== verilog/cpr_por_seq.sv ====
// Purpose: Power-on sequencer driving the open-drain reset line
// Assumes: Supply-good levels are synchronous to the clock
// Notes: Counter restarts whenever a threshold is lost
`timescale 1ns/1ns
module cpr_por_seq #(
  parameter int unsigned DELAY_CYC = cpr_pkg::RELEASE_DELAY_CYC,
  parameter bit PARALLEL = 1'b1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_core_good,
  input wire logic i_out_good,
  output logic o_hold_low,
  output logic o_powered
);
  typedef struct packed {
    cpr_pkg::cpr_por_state_type state;
    logic [31:0] count;
  } cpr_seq_type;

  cpr_seq_type cur;
  cpr_seq_type next_cur;
  logic supplies_ok;

  // Variant decides which supplies gate release
  assign supplies_ok = PARALLEL ? (i_core_good & i_out_good) // (R5)
                                : i_core_good; // (R4)

  // Ramp, delay, ready sequence
  always_comb begin
    next_cur = cur;
    unique case (cur.state)
      cpr_pkg::CPR_RAMP: begin
        next_cur.count = '0;
        if (supplies_ok) begin
          next_cur.state = cpr_pkg::CPR_DELAY;
        end
      end
      cpr_pkg::CPR_DELAY: begin
        if (!supplies_ok) begin
          next_cur.state = cpr_pkg::CPR_RAMP; // (R18)
          next_cur.count = '0; // (R18)
        end else if (cur.count >= 32'(DELAY_CYC - 1)) begin
          next_cur.state = cpr_pkg::CPR_READY; // (R2)
        end else begin
          next_cur.count = cur.count + 32'h0000_0001;
        end
      end
      cpr_pkg::CPR_READY: begin
        if (!supplies_ok) begin
          next_cur.state = cpr_pkg::CPR_RAMP; // (R3)
          next_cur.count = '0;
        end
      end
      // Unused state code falls back to holding the line
      default: begin
        next_cur.state = cpr_pkg::CPR_RAMP;
        next_cur.count = '0;
      end
    endcase
  end

  // State register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cur <= '{state: cpr_pkg::CPR_RAMP, count: 32'h0000_0000};
    end else begin
      cur <= next_cur;
    end
  end

  // Line held low until ready; polarity fixed, no option
  assign o_hold_low = (cur.state != cpr_pkg::CPR_READY); // (R1) (R6)
  assign o_powered = (cur.state == cpr_pkg::CPR_READY);
endmodule

// ==== verilog/cpr_clk_div.sv ====
// Purpose: Divider making the configuration clock output
// Assumes: Single reference clock
// Notes: Rising-edge enable pulse, output parks low when stopped
`timescale 1ns/1ns
module cpr_clk_div #(
  parameter int unsigned HALF_CYC = cpr_pkg::CONFIG_CLOCK_OUT_HALF_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_run,
  output logic o_clk,
  output logic o_rise
);
  typedef struct packed {
    logic [15:0] count;
    logic level;
    logic rise;
  } cpr_div_type;

  cpr_div_type cur;
  cpr_div_type next_cur;

  // Count half periods, flag each rising edge
  always_comb begin
    next_cur = cur;
    next_cur.rise = 1'b0;
    if (!i_run) begin
      next_cur.count = '0;
      next_cur.level = 1'b0;
    end else if (cur.count >= 16'(HALF_CYC - 1)) begin
      next_cur.count = '0;
      next_cur.level = ~cur.level;
      next_cur.rise = ~cur.level;
    end else begin
      next_cur.count = cur.count + 16'h0001;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cur <= '{count: 16'h0000, level: 1'b0, rise: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  assign o_clk = cur.level;
  assign o_rise = cur.rise;
endmodule

// ==== verilog/cpr_top.sv ====
// Purpose: Reset and pin control of a configuration memory
// Assumes: Supply-good and pin inputs synchronous to i_ref_clk
// Notes: Open-drain and tristate pins as in/out/enable, enable low drives
// Function
// (R1) Drive the reset line low while supplies ramp at power-on.
// (R2) Hold the line low a minimum delay after thresholds are met.
// (R3) On supply loss, reset and drive the line low again.
// (R4) Serial variant releases on core supply only.
// (R5) Parallel variant also waits for output supply good.
// (R6) The line is always active low; no inversion option.
// (R7) Enter reset when the line is low or chip enable high.
// (R8) In reset clear address, chain output high, others tristated; the pulse pin enable is not gated by reset.
// (R9) External monitor may hold the line low to delay configuration.
// (R10) Target starts configuring when the shared line goes high.
// (R11) Pulse pin output-only serially, two-way in parallel, idles high.
// (R12) Busy input only exists on the parallel variant.
// (R13) Unused busy input is left open or held low outside.
// (R14) Target select and write held low outside in parallel mode.
// (R15) Parallel variant may drive a configuration clock out.
// (R16) Count per transfer to terminal count, then hold, tristate, chain low.
// (R17) Chip enable high means standby with address reset, chain high.
// (R18) Release delay restarts if a threshold drops mid-delay.
`timescale 1ns/1ns
module cpr_top #(
  parameter bit PARALLEL = 1'b1,
  parameter int unsigned ADDR_W = cpr_pkg::ADDR_W,
  parameter int unsigned DELAY_CYC = cpr_pkg::RELEASE_DELAY_CYC,
  parameter int unsigned CLK_HALF = cpr_pkg::CONFIG_CLOCK_OUT_HALF_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_core_good,
  input wire logic i_out_good,
  input wire logic i_oe_reset_n,
  output logic o_oe_reset_n,
  output logic o_oe_reset_n_oe_n,
  input wire logic i_chip_enable_n,
  input wire logic i_busy,
  input wire logic i_use_clock_out,
  input wire logic i_transfer,
  input wire logic [cpr_pkg::DATA_W-1:0] i_mem_data,
  input wire logic i_config_pulse_req,
  input wire logic i_config_pulse_n,
  output logic o_config_pulse_n,
  output logic o_config_pulse_n_oe_n,
  output logic [ADDR_W-1:0] o_address,
  output logic [cpr_pkg::DATA_W-1:0] o_data,
  output logic o_data_oe_n,
  output logic o_chain_enable_out_n,
  output logic o_config_clock_out,
  output logic o_config_clock_out_oe_n,
  output logic o_in_reset
);
  typedef struct packed {
    logic [1:0] rst_sync;
    logic [ADDR_W-1:0] address;
    logic at_tc;
    logic [cpr_pkg::DATA_W-1:0] data;
    logic data_on;
    logic in_reset;
  } cpr_top_type;

  cpr_top_type cur;
  cpr_top_type next_cur;
  logic rst_int;
  logic hold_low;
  logic powered;
  logic line_low;
  logic busy_eff;
  logic clk_run;
  logic clk_rise;
  logic step;
  logic reset_now;

  // Reset release through two flops, the rest uses the copy
  assign rst_int = ~cur.rst_sync[1];

  // Power sequencer for the open-drain reset line
  cpr_por_seq #(
    .DELAY_CYC(DELAY_CYC),
    .PARALLEL(PARALLEL)
  ) u_seq (
    .i_clk(i_ref_clk),
    .i_rst(rst_int),
    .i_core_good(i_core_good),
    .i_out_good(i_out_good),
    .o_hold_low(hold_low),
    .o_powered(powered)
  );

  // Open drain: drive low only while held; else released to pull-up
  assign o_oe_reset_n = 1'b0; // (R6)
  assign o_oe_reset_n_oe_n = ~hold_low; // (R1) (R3)
  // An outside monitor may hold it too, so sense the wire itself
  assign line_low = hold_low | ~i_oe_reset_n; // (R9)

  // Reset while unpowered, line low or chip enable high
  assign reset_now = ~powered | line_low | i_chip_enable_n; // (R7) (R17)

  // Busy ignored on the serial variant
  assign busy_eff = PARALLEL ? i_busy : 1'b0; // (R12)

  // Clock output only runs on parallel variant when selected
  assign clk_run = PARALLEL & i_use_clock_out & ~reset_now
                   & ~cur.at_tc; // (R15)

  cpr_clk_div #(
    .HALF_CYC(CLK_HALF)
  ) u_div (
    .i_clk(i_ref_clk),
    .i_rst(rst_int),
    .i_run(clk_run),
    .o_clk(o_config_clock_out),
    .o_rise(clk_rise)
  );

  // A transfer is an outside strobe or our own clock edge, unless busy
  assign step = (clk_run ? clk_rise : i_transfer) & ~busy_eff;

  // Address counter and data output state
  always_comb begin
    next_cur = cur;
    // Only the second sync stage is read outside the chain
    next_cur.rst_sync = {cur.rst_sync[0], 1'b1};
    next_cur.in_reset = reset_now;
    if (reset_now) begin
      next_cur.address = cpr_pkg::ADDR_RESET[ADDR_W-1:0]; // (R8)
      next_cur.at_tc = 1'b0; // (R8)
      next_cur.data_on = 1'b0; // (R8)
      next_cur.data = '0;
    end else if (cur.at_tc) begin
      next_cur.data_on = 1'b0; // (R16)
    end else begin
      next_cur.data_on = 1'b1;
      if (step) begin
        next_cur.data = i_mem_data;
        if (cur.address == {ADDR_W{1'b1}}) begin
          next_cur.at_tc = 1'b1; // (R16)
          next_cur.data_on = 1'b0; // (R16)
        end else begin
          next_cur.address = cur.address + 1'b1; // (R16)
        end
      end
    end
  end

  // Whole state in one register; sync reset comes via unpowered sequencer
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cur <= '{rst_sync: 2'h0, address: cpr_pkg::ADDR_RESET[ADDR_W-1:0],
               at_tc: 1'b0, data: '0, data_on: 1'b0, in_reset: 1'b1};
    end else begin
      cur <= next_cur;
    end
  end

  // Chain output high in reset, low at terminal count
  assign o_chain_enable_out_n = cur.in_reset | ~cur.at_tc; // (R8) (R16)
  assign o_address = cur.address;
  assign o_data = cur.data;
  assign o_data_oe_n = ~(cur.data_on & ~cur.in_reset); // (R8)
  assign o_config_clock_out_oe_n = ~clk_run; // (R8) (R15)
  assign o_in_reset = cur.in_reset;

  // Pulse pin idles high; serial variant always drives it (output-only)
  assign o_config_pulse_n = ~i_config_pulse_req; // (R11)
  assign o_config_pulse_n_oe_n = PARALLEL ? ~i_config_pulse_req
                                          : 1'b0; // (R11)
endmodule

// ==== testbench/cpr_top_properties.sv ====
// Purpose: Port checker for cpr_top
// Assumes: Clock output unused while stepping
// Notes: Bound to every cpr_top
`timescale 1ns/1ns
module cpr_top_chk #(
  parameter bit PARALLEL = 1'b1,
  parameter int unsigned ADDR_W = 16,
  parameter int unsigned DELAY_CYC = cpr_pkg::RELEASE_DELAY_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_core_good,
  input wire logic i_out_good,
  input wire logic i_oe_reset_n,
  input wire logic o_oe_reset_n,
  input wire logic o_oe_reset_n_oe_n,
  input wire logic i_chip_enable_n,
  input wire logic i_busy,
  input wire logic i_use_clock_out,
  input wire logic i_transfer,
  input wire logic [cpr_pkg::DATA_W-1:0] i_mem_data,
  input wire logic i_config_pulse_req,
  input wire logic o_config_pulse_n,
  input wire logic o_config_pulse_n_oe_n,
  input wire logic [ADDR_W-1:0] o_address,
  input wire logic [cpr_pkg::DATA_W-1:0] o_data,
  input wire logic o_data_oe_n,
  input wire logic o_chain_enable_out_n,
  input wire logic o_in_reset
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  logic [7:0] ok_cnt;
  wire ok = i_core_good && (i_out_good || !PARALLEL);
  // Unbroken run of supply-good cycles, saturates
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
    if (!i_rst_n) ok_cnt <= 8'h00;
    else ok_cnt <= !ok ? 8'h00 : ok_cnt + 8'(ok_cnt != 8'hff);
  sequence s_run;
    !o_in_reset && o_oe_reset_n_oe_n && i_oe_reset_n &&
      !i_chip_enable_n && !i_use_clock_out;
  endsequence
  sequence s_step;
    s_run ##0 (i_transfer && !i_busy);
  endsequence
  property p_fixed_low;
    o_oe_reset_n == 1'b0;
  endproperty
  property p_supply_loss;
    !ok |=> !o_oe_reset_n_oe_n;
  endproperty
  property p_release_delay;
    $rose(o_oe_reset_n_oe_n) |-> ok_cnt > DELAY_CYC;
  endproperty
  property p_reset_outputs;
    (!i_oe_reset_n || i_chip_enable_n) |=> o_in_reset &&
      o_chain_enable_out_n && o_data_oe_n && o_address == '0;
  endproperty
  property p_count;
    s_step ##0 (o_chain_enable_out_n && o_address != '1) |=>
      o_address == $past(o_address) + 1'b1 && o_data == $past(i_mem_data);
  endproperty
  property p_stall;
    s_run ##0 (i_busy && PARALLEL) |=> $stable(o_address);
  endproperty
  property p_terminal;
    s_step ##0 (o_address == '1) |=>
      !o_chain_enable_out_n && o_data_oe_n && o_address == '1;
  endproperty
  property p_pulse_pin;
    o_config_pulse_n == !i_config_pulse_req &&
      o_config_pulse_n_oe_n == (PARALLEL && !i_config_pulse_req);
  endproperty
  a_fixed_low: assert property (p_fixed_low)
    else $error("reset line drive value not low");
  a_supply_loss: assert property (p_supply_loss)
    else $error("line released without supplies");
  a_release_delay: assert property (p_release_delay)
    else $error("line released too early");
  a_reset_outputs: assert property (p_reset_outputs)
    else $error("outputs wrong in reset");
  a_count: assert property (p_count)
    else $error("address or data step wrong");
  a_stall: assert property (p_stall)
    else $error("address moved while busy");
  a_terminal: assert property (p_terminal)
    else $error("terminal count outputs wrong");
  a_pulse_pin: assert property (p_pulse_pin)
    else $error("pulse pin wrong");
endmodule
bind cpr_top cpr_top_chk #(.PARALLEL(PARALLEL), .ADDR_W(ADDR_W),
  .DELAY_CYC(DELAY_CYC)) i_cpr_top_chk (.i_ref_clk, .i_rst_n,
  .i_core_good, .i_out_good, .i_oe_reset_n, .o_oe_reset_n,
  .o_oe_reset_n_oe_n, .i_chip_enable_n, .i_busy, .i_use_clock_out,
  .i_transfer, .i_mem_data, .i_config_pulse_req, .o_config_pulse_n,
  .o_config_pulse_n_oe_n, .o_address, .o_data, .o_data_oe_n,
  .o_chain_enable_out_n, .o_in_reset);

// ==== testbench/cpr_target_model.sv ====
// Purpose: Target configuration port model
// Assumes: Pull-ups on reset line and pulse pin
// Notes: Monitor hold, busy, select and write levels come from the bench
`timescale 1ns/1ns
module cpr_target_model (
  input wire logic i_clk,
  input wire logic i_line_oe_n,
  input wire logic i_pulse_n,
  input wire logic i_pulse_oe_n,
  input wire logic i_hold_n,
  input wire logic i_use_busy,
  input wire logic i_busy_req,
  input wire logic i_select_n,
  input wire logic i_write_n,
  output logic o_line,
  output logic o_pulse,
  output logic o_busy,
  output logic o_started
);
  // Wired levels: pull-up unless a party pulls low
  assign o_line = i_line_oe_n && i_hold_n;
  assign o_pulse = i_pulse_oe_n || i_pulse_n;
  // Busy unused means held low
  assign o_busy = i_use_busy && i_busy_req;
  // Configuration may begin once the line is high
  // Byte-wide load also needs select and write held low
  always_ff @(posedge i_clk)
    o_started <= o_line && !i_select_n && !i_write_n;
endmodule

// ==== testbench/cpr_top_tb.sv ====
// Purpose: Self-checking bench for cpr_top
// Assumes: Short release delay and 4-bit address
// Notes: Monitor pops one note per address move to a nonzero value
`timescale 1ns/1ns
module cpr_top_tb;
  localparam int unsigned DLY = 4;
  logic clk = 0, rst_n = 0, core = 0, outg = 0, ce_n = 1, hold_n = 1;
  logic busy_req = 0, xfer = 0, preq = 0, uclk = 0;
  logic [7:0] dat = 8'h00;
  wire line, pulse, busy, oe_n, pn, pn_oe_n, chain, d_oe_n, in_rst;
  wire started, s_oe_n, s_pn_oe_n, ck_oe_n, s_ck_oe_n;
  wire [3:0] addr;
  wire [7:0] odat;
  int fail_count = 0, checks = 0, cyc = 0, seed = 32'hac19, r, ea;
  logic [11:0] exp_q[$];
  logic [3:0] prev = 4'h0;
  always #5 clk = ~clk;
  cpr_top #(.PARALLEL(1'b1), .ADDR_W(4), .DELAY_CYC(DLY), .CLK_HALF(2))
  i_cpr_top (.i_ref_clk(clk), .i_rst_n(rst_n), .i_core_good(core),
    .i_out_good(outg), .i_oe_reset_n(line), .o_oe_reset_n(),
    .o_oe_reset_n_oe_n(oe_n), .i_chip_enable_n(ce_n), .i_busy(busy),
    .i_use_clock_out(uclk), .i_transfer(xfer), .i_mem_data(dat),
    .i_config_pulse_req(preq), .i_config_pulse_n(pulse),
    .o_config_pulse_n(pn), .o_config_pulse_n_oe_n(pn_oe_n),
    .o_address(addr), .o_data(odat), .o_data_oe_n(d_oe_n),
    .o_chain_enable_out_n(chain), .o_config_clock_out(),
    .o_config_clock_out_oe_n(ck_oe_n), .o_in_reset(in_rst));
  // Serial variant on the same stimulus, released by its own drive only
  cpr_top #(.PARALLEL(1'b0), .ADDR_W(4), .DELAY_CYC(DLY), .CLK_HALF(2))
  i_cpr_top_ser (.i_ref_clk(clk), .i_rst_n(rst_n), .i_core_good(core),
    .i_out_good(1'b0), .i_oe_reset_n(s_oe_n), .o_oe_reset_n(),
    .o_oe_reset_n_oe_n(s_oe_n), .i_chip_enable_n(ce_n), .i_busy(busy),
    .i_use_clock_out(uclk), .i_transfer(xfer), .i_mem_data(dat),
    .i_config_pulse_req(preq), .i_config_pulse_n(1'b1),
    .o_config_pulse_n(), .o_config_pulse_n_oe_n(s_pn_oe_n),
    .o_address(), .o_data(), .o_data_oe_n(),
    .o_chain_enable_out_n(), .o_config_clock_out(),
    .o_config_clock_out_oe_n(s_ck_oe_n), .o_in_reset());
  cpr_target_model i_cpr_target_model (.i_clk(clk), .i_line_oe_n(oe_n),
    .i_pulse_n(pn), .i_pulse_oe_n(pn_oe_n), .i_hold_n(hold_n),
    .i_use_busy(1'b1), .i_busy_req(busy_req), .o_line(line),
    .o_pulse(pulse), .o_busy(busy), .o_started(started),
    .i_select_n(1'b0), .i_write_n(1'b0));
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("fail_count=%0d checks=%0d", fail_count, checks);
    if (fail_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Each address move to a nonzero value is one accepted word
  always @(posedge clk) begin
    #2;
    if (addr !== prev && addr !== 4'h0) begin
      if (exp_q.size() == 0) chk({addr, odat}, 12'hfff);
      else chk({addr, odat}, exp_q.pop_front());
    end
    prev = addr;
  end
  // Hang guard, well past the expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      test_done;
    end
  end
  initial begin
    step(12);
    rst_n = 1;
    step(4);
    chk({oe_n, chain, started}, 12'h002);
    core = 1;
    step(10);
    chk({oe_n, s_oe_n}, 12'h001);
    outg = 1;
    step(2);
    core = 0;
    step(1);
    core = 1;
    step(DLY);
    chk(oe_n, 0);
    step(2);
    chk({oe_n, in_rst, started}, 12'h007);
    hold_n = 0;
    ce_n = 0;
    step(3);
    chk(in_rst, 1);
    hold_n = 1;
    step(2);
    chk(in_rst, 0);
    ea = 0;
    // Random busy stalls between back-to-back words
    while (ea < 16) begin
      r = $random(seed);
      busy_req = r[0];
      dat = r[15:8];
      xfer = 1;
      if (!busy_req) begin
        ea++;
        if (ea < 16) exp_q.push_back({ea[3:0], dat});
      end
      step(1);
    end
    busy_req = 0;
    step(3);
    xfer = 0;
    chk({chain, d_oe_n, addr}, 12'h01f);
    chk(12'(exp_q.size()), 0);
    ce_n = 1;
    step(2);
    chk({chain, d_oe_n, addr}, 12'h030);
    // Own clock output: one step per full period of the divided clock
    dat = 8'h5a;
    exp_q.push_back({4'h1, dat});
    exp_q.push_back({4'h2, dat});
    uclk = 1;
    ce_n = 0;
    step(8);
    chk({ck_oe_n, s_ck_oe_n, addr, 4'(exp_q.size())}, 12'h120);
    uclk = 0;
    ce_n = 1;
    step(2);
    for (int i = 0; i < 4; i++) begin
      preq = i[0];
      step(1);
      chk({pn, pn_oe_n, pulse, s_pn_oe_n}, {8'h00, {3{~preq}}, 1'b0});
    end
    core = 0;
    step(2);
    chk({oe_n, in_rst}, 12'h001);
    // Reset in mid-run, then a clean release with supplies up
    core = 1;
    rst_n = 0;
    step(1);
    chk({oe_n, chain, d_oe_n, in_rst}, 12'h007);
    rst_n = 1;
    step(6);
    chk({oe_n, s_oe_n}, 12'h000);
    step(1);
    chk({oe_n, s_oe_n}, 12'h003);
    test_done;
  end
endmodule
